// file: pkg/dsb_regs.svh
`ifndef DSB_REGS_SVH
`define DSB_REGS_SVH

// serial frame: 1 direction bit, 15 address bits, 8 data bits
`define DSB_ADDR_W 15
`define DSB_CNT_W 5
`define DSB_CMD_LAST 5'h0F
`define DSB_FRAME_LAST 5'h17
`define DSB_FRAME_BITS 5'h18
`define DSB_RW_BIT_CMD 14
`define DSB_RW_BIT_FRAME 22

// register byte offsets
`define DSB_OFS_CONFIG_A 15'h0000
`define DSB_OFS_DEVICE_CONFIG 15'h0002
`define DSB_OFS_PART_TYPE 15'h0003
`define DSB_OFS_PART_LOW 15'h0004
`define DSB_OFS_PART_HIGH 15'h0005
`define DSB_OFS_SI_REV 15'h0006
`define DSB_OFS_MAKER_LOW 15'h000C
`define DSB_OFS_MAKER_HIGH 15'h000D
`define DSB_OFS_SREF_CTRL 15'h0080
`define DSB_OFS_SREF_POS0 15'h0090
`define DSB_OFS_SREF_POS1 15'h0091
`define DSB_OFS_SREF_POS2 15'h0092
`define DSB_OFS_SREF_ALIGN 15'h00A0
`define DSB_OFS_SREF_CFG 15'h00A1
`define DSB_OFS_LINK_EN 15'h0100
`define DSB_OFS_LINK_MODE 15'h0101
`define DSB_OFS_STREAMS 15'h0102
`define DSB_OFS_LINK_CTRL 15'h0103
`define DSB_OFS_SH_MODE 15'h0104
`define DSB_OFS_KM1 15'h0105
`define DSB_OFS_RBD 15'h0106
`define DSB_OFS_LINK_STAT 15'h0107
`define DSB_OFS_REF_DIV 15'h0108
`define DSB_OFS_PLL_MUL 15'h0109

// reset values
`define DSB_RST_CONFIG_A 8'h30
`define DSB_RST_ZERO 8'h00
`define DSB_RST_SREF_CTRL 8'h40
`define DSB_RST_STREAMS 8'h01
`define DSB_RST_LINK_CTRL 8'h03
`define DSB_RST_KM1 8'h1F
`define DSB_RST_REF_DIV 8'h30
`define DSB_RST_PLL_MUL 8'h14

// fields
`define DSB_SOFT_RESET_BIT 7
`define DSB_LINK_EN_BIT 0
`define DSB_CFGA_KEEP 8'h7F
`define DSB_MODE_ZERO 8'h00

// timing
`define DSB_CLK_PERIOD_NS 10
`define DSB_SRST_NS 150
`define DSB_SRST_CYCLES ((`DSB_SRST_NS + `DSB_CLK_PERIOD_NS - 1) / `DSB_CLK_PERIOD_NS)
`define DSB_SRST_CNT_W 5

// link checks
`define DSB_LANES_W 5
`define DSB_RATE_W 14
`define DSB_RATE_MIN_MBPS 14'h02EE
`define DSB_RATE_MAX_MBPS 14'h3200
`define DSB_PRBS_SEL_W 3
`define DSB_PRBS_W 5
`define DSB_PRBS_OFF 5'h00
`define DSB_PRBS_7 5'h07
`define DSB_PRBS_9 5'h09
`define DSB_PRBS_15 5'h0F
`define DSB_PRBS_31 5'h1F
`define DSB_INTERP_W 9
`define DSB_INTERP_MIN 9'h002
`define DSB_SAMPLE_W 16
`define DSB_MAG_SQ_W 33
`define DSB_MAG_SQ_LIMIT 33'h03FFF0001

`endif

// file: pkg/dsb_pkg.sv
package dsb_pkg;
    typedef enum logic [0:0] {
        DSB_RUN = 1'b0,
        DSB_SRST = 1'b1
    } dsb_state_t;
    typedef logic [7:0] dsb_byte_t;
endpackage : dsb_pkg

// file: verilog/dsb_spi_frame.sv
`timescale 1ns/100ps
`default_nettype none
`include "dsb_regs.svh"

module dsb_spi_frame (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic hold,
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    input wire dsb_pkg::dsb_byte_t rdData,
    output logic rdReq_q,
    output logic wrReq_q,
    output logic [`DSB_ADDR_W-1:0] addr_q,
    output dsb_pkg::dsb_byte_t wrData_q,
    output logic spiMiso_q,
    output logic spiMisoEn_q
);
    logic sclkPrev_q;
    logic [`DSB_CNT_W-1:0] bitCnt_q;
    logic [`DSB_FRAME_LAST-1:0] shift_q;
    dsb_pkg::dsb_byte_t txShift_q;
    logic reading_q;
    logic idle;
    logic rise;
    logic fall;

    // inputs are taken as synchronous; sclk edges come from a one-flop history
    assign idle = rst | hold | spiCsN;
    assign rise = spiSclk & ~sclkPrev_q & ~idle & (bitCnt_q != `DSB_FRAME_BITS);
    assign fall = ~spiSclk & sclkPrev_q & ~idle;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sclkPrev_q <= 1'b0;
        end else begin
            sclkPrev_q <= spiSclk;
        end
    end

    always_ff @(posedge core_clk) begin
        if (idle) begin
            bitCnt_q <= '0;
            shift_q <= '0;
        end else if (rise) begin
            bitCnt_q <= bitCnt_q + 1'b1;
            shift_q <= {shift_q[`DSB_FRAME_LAST-2:0], spiMosi};
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdReq_q <= 1'b0;
            wrReq_q <= 1'b0;
            addr_q <= '0;
            wrData_q <= '0;
            reading_q <= 1'b0;
        end else begin
            rdReq_q <= rise && bitCnt_q == `DSB_CMD_LAST && shift_q[`DSB_RW_BIT_CMD];
            wrReq_q <= rise && bitCnt_q == `DSB_FRAME_LAST && !shift_q[`DSB_RW_BIT_FRAME];
            if (rise && bitCnt_q == `DSB_CMD_LAST) begin
                addr_q <= {shift_q[`DSB_ADDR_W-2:0], spiMosi};
                reading_q <= shift_q[`DSB_RW_BIT_CMD];
            end
            if (rise && bitCnt_q == `DSB_FRAME_LAST) begin
                wrData_q <= {shift_q[6:0], spiMosi};
            end
            if (idle) begin
                reading_q <= 1'b0;
            end
        end
    end

    // read data leaves msb first, one bit per falling sclk after the address
    always_ff @(posedge core_clk) begin
        if (rst) begin
            txShift_q <= '0;
            spiMiso_q <= 1'b0;
            spiMisoEn_q <= 1'b0;
        end else begin
            spiMisoEn_q <= reading_q && !idle && bitCnt_q > `DSB_CMD_LAST;
            if (rdReq_q) begin
                txShift_q <= rdData;
            end else if (fall && reading_q) begin
                spiMiso_q <= txShift_q[7];
                txShift_q <= {txShift_q[6:0], 1'b0};
            end
        end
    end
endmodule : dsb_spi_frame
`default_nettype wire

// file: verilog/dsb_config_bank.sv
`timescale 1ns/100ps
`default_nettype none
`include "dsb_regs.svh"

module dsb_config_bank #(
    parameter logic [7:0] PART_TYPE = 8'hA5, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h5A3C, // arbitrary value
    parameter logic [7:0] SI_REVISION = 8'h1E, // arbitrary value
    parameter logic [15:0] MAKER_CODE = 16'hC3D2 // arbitrary value
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic spiSclk,
    input wire logic spiCsN,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoEn,
    input wire logic [23:0] sysrefPosition,
    input wire logic [`DSB_LANES_W-1:0] laneCountReq,
    input wire logic [`DSB_PRBS_SEL_W-1:0] testPatternSel,
    input wire logic [`DSB_RATE_W-1:0] laneRateMbps,
    input wire logic datapathEnable,
    input wire logic [`DSB_INTERP_W-1:0] interpFactor,
    input wire logic signed [`DSB_SAMPLE_W-1:0] linkI,
    input wire logic signed [`DSB_SAMPLE_W-1:0] linkQ,
    input wire logic signed [`DSB_SAMPLE_W-1:0] constI,
    input wire logic signed [`DSB_SAMPLE_W-1:0] constQ,
    output logic linkEnable_q,
    output dsb_pkg::dsb_byte_t linkModeSelect_q,
    output dsb_pkg::dsb_byte_t linkStreamCount_q,
    output dsb_pkg::dsb_byte_t linkControl_q,
    output logic resetBusy_q,
    output logic [`DSB_LANES_W-1:0] laneCount_q,
    output logic laneCountOk_q,
    output logic [`DSB_PRBS_W-1:0] prbsOrder_q,
    output logic laneRateOk_q,
    output logic upConverterBypass_q,
    output logic complexSamples_q,
    output logic oscillatorOnlyMode_q,
    output logic signed [`DSB_SAMPLE_W-1:0] mixI_q,
    output logic signed [`DSB_SAMPLE_W-1:0] mixQ_q,
    output logic mixSat_q,
    output logic signed [`DSB_SAMPLE_W-1:0] dacSample_q
);
    dsb_pkg::dsb_state_t state_q;
    logic [`DSB_SRST_CNT_W-1:0] srstCnt_q;
    logic rdReq;
    logic wrReq;
    logic [`DSB_ADDR_W-1:0] addr;
    dsb_pkg::dsb_byte_t wrData;
    dsb_pkg::dsb_byte_t rdData;
    logic srstStart;
    logic regReset;
    dsb_pkg::dsb_byte_t configA_q, deviceConfig_q, syncRefCtrl_q, syncRefAlign_q;
    dsb_pkg::dsb_byte_t syncRefCfg_q, syncHeaderMode_q, multiframeLen_q, releaseDelay_q;
    dsb_pkg::dsb_byte_t linkStatus_q, refDivider_q, pllMultiplier_q;
    logic laneLegal;
    logic [`DSB_PRBS_W-1:0] prbsSel;
    logic oscCond;
    logic signed [`DSB_SAMPLE_W-1:0] srcI, srcQ;
    logic [`DSB_MAG_SQ_W-1:0] magSq;

    // serial port is parked while the soft reset runs
    dsb_spi_frame i_dsb_spi_frame (
        .core_clk(core_clk),
        .rst(rst),
        .hold(state_q == dsb_pkg::DSB_SRST),
        .spiSclk(spiSclk),
        .spiCsN(spiCsN),
        .spiMosi(spiMosi),
        .rdData(rdData),
        .rdReq_q(rdReq),
        .wrReq_q(wrReq),
        .addr_q(addr),
        .wrData_q(wrData),
        .spiMiso_q(spiMiso),
        .spiMisoEn_q(spiMisoEn)
    );

    assign srstStart = wrReq && addr == `DSB_OFS_CONFIG_A && wrData[`DSB_SOFT_RESET_BIT];
    assign regReset = rst || state_q == dsb_pkg::DSB_SRST;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= dsb_pkg::DSB_RUN;
            srstCnt_q <= '0;
        end else begin
            unique case (state_q)
                dsb_pkg::DSB_RUN: begin
                    if (srstStart) begin
                        state_q <= dsb_pkg::DSB_SRST;
                        srstCnt_q <= `DSB_SRST_CNT_W'(`DSB_SRST_CYCLES - 1);
                    end
                end
                dsb_pkg::DSB_SRST: begin
                    if (srstCnt_q == '0) begin
                        state_q <= dsb_pkg::DSB_RUN;
                    end else begin
                        srstCnt_q <= srstCnt_q - 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            resetBusy_q <= 1'b0;
        end else begin
            resetBusy_q <= srstStart || (state_q == dsb_pkg::DSB_SRST && srstCnt_q != '0);
        end
    end

    // writes; read-only offsets have no entry and are dropped
    always_ff @(posedge core_clk) begin
        if (regReset || srstStart) begin
            configA_q <= `DSB_RST_CONFIG_A;
            deviceConfig_q <= `DSB_RST_ZERO;
            syncRefCtrl_q <= `DSB_RST_SREF_CTRL;
            syncRefAlign_q <= `DSB_RST_ZERO;
            syncRefCfg_q <= `DSB_RST_ZERO;
            linkEnable_q <= 1'b0;
            linkModeSelect_q <= `DSB_RST_ZERO;
            linkStreamCount_q <= `DSB_RST_STREAMS;
            linkControl_q <= `DSB_RST_LINK_CTRL;
            syncHeaderMode_q <= `DSB_RST_ZERO;
            multiframeLen_q <= `DSB_RST_KM1;
            releaseDelay_q <= `DSB_RST_ZERO;
            linkStatus_q <= `DSB_RST_ZERO;
            refDivider_q <= `DSB_RST_REF_DIV;
            pllMultiplier_q <= `DSB_RST_PLL_MUL;
        end else if (wrReq) begin
            case (addr)
                `DSB_OFS_CONFIG_A: configA_q <= wrData & `DSB_CFGA_KEEP;
                `DSB_OFS_DEVICE_CONFIG: deviceConfig_q <= wrData;
                `DSB_OFS_SREF_CTRL: syncRefCtrl_q <= wrData;
                `DSB_OFS_SREF_ALIGN: syncRefAlign_q <= wrData;
                `DSB_OFS_SREF_CFG: syncRefCfg_q <= wrData;
                `DSB_OFS_LINK_EN: linkEnable_q <= wrData[`DSB_LINK_EN_BIT];
                `DSB_OFS_LINK_MODE: linkModeSelect_q <= wrData;
                `DSB_OFS_STREAMS: linkStreamCount_q <= wrData;
                `DSB_OFS_LINK_CTRL: linkControl_q <= wrData;
                `DSB_OFS_SH_MODE: syncHeaderMode_q <= wrData;
                `DSB_OFS_KM1: multiframeLen_q <= wrData;
                `DSB_OFS_RBD: releaseDelay_q <= wrData;
                `DSB_OFS_LINK_STAT: linkStatus_q <= wrData;
                `DSB_OFS_REF_DIV: refDivider_q <= wrData;
                `DSB_OFS_PLL_MUL: pllMultiplier_q <= wrData;
                default: ;
            endcase
        end
    end

    // unmapped offsets read as zero
    always_comb begin
        rdData = `DSB_RST_ZERO;
        case (addr)
            `DSB_OFS_CONFIG_A: rdData = configA_q;
            `DSB_OFS_DEVICE_CONFIG: rdData = deviceConfig_q;
            `DSB_OFS_PART_TYPE: rdData = PART_TYPE;
            `DSB_OFS_PART_LOW: rdData = PART_CODE[7:0];
            `DSB_OFS_PART_HIGH: rdData = PART_CODE[15:8];
            `DSB_OFS_SI_REV: rdData = SI_REVISION;
            `DSB_OFS_MAKER_LOW: rdData = MAKER_CODE[7:0];
            `DSB_OFS_MAKER_HIGH: rdData = MAKER_CODE[15:8];
            `DSB_OFS_SREF_CTRL: rdData = syncRefCtrl_q;
            `DSB_OFS_SREF_POS0: rdData = sysrefPosition[7:0];
            `DSB_OFS_SREF_POS1: rdData = sysrefPosition[15:8];
            `DSB_OFS_SREF_POS2: rdData = sysrefPosition[23:16];
            `DSB_OFS_SREF_ALIGN: rdData = syncRefAlign_q;
            `DSB_OFS_SREF_CFG: rdData = syncRefCfg_q;
            `DSB_OFS_LINK_EN: rdData = {7'h00, linkEnable_q};
            `DSB_OFS_LINK_MODE: rdData = linkModeSelect_q;
            `DSB_OFS_STREAMS: rdData = linkStreamCount_q;
            `DSB_OFS_LINK_CTRL: rdData = linkControl_q;
            `DSB_OFS_SH_MODE: rdData = syncHeaderMode_q;
            `DSB_OFS_KM1: rdData = multiframeLen_q;
            `DSB_OFS_RBD: rdData = releaseDelay_q;
            `DSB_OFS_LINK_STAT: rdData = linkStatus_q;
            `DSB_OFS_REF_DIV: rdData = refDivider_q;
            `DSB_OFS_PLL_MUL: rdData = pllMultiplier_q;
            default: rdData = `DSB_RST_ZERO;
        endcase
    end

    // lane count, pattern and rate checks
    always_comb begin
        case (laneCountReq)
            5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0C, 5'h10: laneLegal = 1'b1;
            default: laneLegal = 1'b0;
        endcase
        case (testPatternSel)
            3'h1: prbsSel = `DSB_PRBS_7;
            3'h2: prbsSel = `DSB_PRBS_9;
            3'h3: prbsSel = `DSB_PRBS_15;
            3'h4: prbsSel = `DSB_PRBS_31;
            default: prbsSel = `DSB_PRBS_OFF;
        endcase
    end

    // an illegal request keeps the last legal lane count
    always_ff @(posedge core_clk) begin
        if (regReset) begin
            laneCount_q <= 5'h01;
            laneCountOk_q <= 1'b0;
            prbsOrder_q <= `DSB_PRBS_OFF;
            laneRateOk_q <= 1'b0;
        end else begin
            laneCountOk_q <= laneLegal;
            if (laneLegal) begin
                laneCount_q <= laneCountReq;
            end
            prbsOrder_q <= prbsSel;
            laneRateOk_q <= laneRateMbps >= `DSB_RATE_MIN_MBPS
                && laneRateMbps <= `DSB_RATE_MAX_MBPS;
        end
    end

    // datapath selection follows the registers live; safe only if the link is off meanwhile
    assign oscCond = !linkEnable_q && datapathEnable && interpFactor >= `DSB_INTERP_MIN;
    assign srcI = oscCond ? constI : linkI;
    assign srcQ = oscCond ? constQ : linkQ;
    assign magSq = `DSB_MAG_SQ_W'(srcI * srcI) + `DSB_MAG_SQ_W'(srcQ * srcQ);

    always_ff @(posedge core_clk) begin
        if (regReset) begin
            upConverterBypass_q <= 1'b1;
            complexSamples_q <= 1'b0;
            oscillatorOnlyMode_q <= 1'b0;
            mixI_q <= '0;
            mixQ_q <= '0;
            mixSat_q <= 1'b0;
            dacSample_q <= '0;
        end else begin
            upConverterBypass_q <= linkModeSelect_q == `DSB_MODE_ZERO;
            complexSamples_q <= linkModeSelect_q != `DSB_MODE_ZERO;
            oscillatorOnlyMode_q <= oscCond;
            mixI_q <= srcI;
            mixQ_q <= srcQ;
            mixSat_q <= magSq > `DSB_MAG_SQ_LIMIT;
            dacSample_q <= (linkModeSelect_q == `DSB_MODE_ZERO) ? linkI : srcI;
        end
    end

    // helper: length of the soft-reset hold
    logic [`DSB_SRST_CNT_W-1:0] holdLen_q;
    always_ff @(posedge core_clk) begin
        if (rst || state_q == dsb_pkg::DSB_RUN) begin
            holdLen_q <= '0;
        end else begin
            holdLen_q <= holdLen_q + 1'b1;
        end
    end

    AST_SRST_DEFAULTS: assert property (@(posedge core_clk) disable iff (rst)
        srstStart |=> ##1 (configA_q == `DSB_RST_CONFIG_A && !linkEnable_q
            && linkControl_q == `DSB_RST_LINK_CTRL))
        else $error("soft reset did not restore defaults");
    AST_SRST_READS_ZERO: assert property (@(posedge core_clk) disable iff (rst)
        !configA_q[`DSB_SOFT_RESET_BIT] && !(rdReq && addr == `DSB_OFS_CONFIG_A
            && rdData[`DSB_SOFT_RESET_BIT]))
        else $error("reset bit read back as one");
    AST_SRST_LENGTH: assert property (@(posedge core_clk) disable iff (rst)
        $fell(state_q) |-> $past(holdLen_q) == `DSB_SRST_CNT_W'(`DSB_SRST_CYCLES - 1))
        else $error("soft reset length wrong");
    AST_SRST_NO_ACCESS: assert property (@(posedge core_clk) disable iff (rst)
        srstStart |=> (!wrReq && !rdReq) [*8])
        else $error("serial access during soft reset");
    AST_RESET_VALUES: assert property (@(posedge core_clk)
        $past(rst) |-> (multiframeLen_q == `DSB_RST_KM1 && refDivider_q == `DSB_RST_REF_DIV
            && pllMultiplier_q == `DSB_RST_PLL_MUL && syncRefCtrl_q == `DSB_RST_SREF_CTRL))
        else $error("register default wrong after reset");
    AST_LANE_LEGAL: assert property (@(posedge core_clk) disable iff (rst)
        laneCountOk_q |-> laneCount_q == $past(laneCountReq))
        else $error("legal lane count not taken");
    AST_PRBS_ORDER: assert property (@(posedge core_clk) disable iff (rst)
        $past(testPatternSel) == 3'h4 && !$past(regReset) |-> prbsOrder_q == `DSB_PRBS_31)
        else $error("wrong pattern order");
    AST_RATE_RANGE: assert property (@(posedge core_clk) disable iff (rst)
        !$past(regReset) |-> laneRateOk_q == ($past(laneRateMbps) >= `DSB_RATE_MIN_MBPS
            && $past(laneRateMbps) <= `DSB_RATE_MAX_MBPS))
        else $error("lane rate check wrong");
    AST_BYPASS_REAL: assert property (@(posedge core_clk) disable iff (rst)
        $past(linkModeSelect_q) == `DSB_MODE_ZERO && !$past(regReset)
            |-> dacSample_q == $past(linkI) && upConverterBypass_q)
        else $error("mode zero not bypassed");
    AST_OSC_ONLY: assert property (@(posedge core_clk) disable iff (rst)
        oscillatorOnlyMode_q |-> mixI_q == $past(constI) && !$past(linkEnable_q))
        else $error("oscillator-only source wrong");
    AST_MIX_SAT: assert property (@(posedge core_clk) disable iff (rst)
        !$past(regReset) |-> mixSat_q == ($past(magSq) > `DSB_MAG_SQ_LIMIT))
        else $error("mixer saturation flag wrong");

    COV_SOFT_RESET: cover property (@(posedge core_clk) disable iff (rst) srstStart);
    COV_READ: cover property (@(posedge core_clk) disable iff (rst) rdReq);
    COV_OSC_ONLY: cover property (@(posedge core_clk) disable iff (rst) oscillatorOnlyMode_q);
    COV_SAT: cover property (@(posedge core_clk) disable iff (rst) mixSat_q);
endmodule : dsb_config_bank
`default_nettype wire

// file: bench/dsb_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
module dsb_spi_host (
    input wire logic core_clk,
    output logic spiSclk,
    output logic spiCsN,
    output logic spiMosi,
    input wire logic spiMiso,
    input wire logic spiMisoEn
);
    int halfCyc = 4;
    initial begin
        spiSclk = 1'b0;
        spiCsN = 1'b1;
        spiMosi = 1'b0;
    end
    // one frame, msb first; sclk stays low outside frames
    task automatic xfer(input logic rdNotWr, input logic [14:0] addr, input logic [7:0] wrVal,
        output logic [7:0] rdVal);
        logic [23:0] frame;
        frame = {rdNotWr, addr, wrVal};
        rdVal = 8'h00;
        @(negedge core_clk);
        spiCsN = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spiMosi = frame[i];
            repeat (halfCyc) @(negedge core_clk);
            // released miso shows the inverse so a late enable shows up
            if (i < 8) rdVal = {rdVal[6:0], spiMisoEn ? spiMiso : ~spiMiso};
            spiSclk = 1'b1;
            repeat (halfCyc) @(negedge core_clk);
            spiSclk = 1'b0;
        end
        repeat (halfCyc) @(negedge core_clk);
        spiCsN = 1'b1;
        spiMosi = ~spiMosi;
        repeat (3) @(negedge core_clk);
    endtask : xfer
endmodule : dsb_spi_host
`default_nettype wire

// file: bench/dsb_config_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module dsb_config_bank_tb;
    logic core_clk, rst, spiSclk, spiCsN, spiMosi, spiMiso, spiMisoEn;
    logic [23:0] sysrefPosition = 24'h96A53C;
    logic [4:0] laneCountReq = 5'h01;
    logic [2:0] testPatternSel = 3'h0;
    logic [13:0] laneRateMbps = 14'h03E8;
    logic datapathEnable = 1'b0;
    logic [8:0] interpFactor = 9'h001;
    // link samples in two's-complement form, a negative I code
    logic signed [15:0] linkI = 16'h9234, linkQ = 16'h0100, constI = 16'h0000, constQ = 16'h0000;
    logic linkEnable_q, resetBusy_q, laneCountOk_q, laneRateOk_q, upConverterBypass_q;
    logic complexSamples_q, oscillatorOnlyMode_q, mixSat_q;
    logic [7:0] linkModeSelect_q, linkStreamCount_q, linkControl_q, rdv;
    logic [4:0] prbsOrder_q, laneCount_q;
    logic signed [15:0] mixI_q, mixQ_q, dacSample_q;
    logic [4:0] prbsExp [0:7] = '{5'h00, 5'h07, 5'h09, 5'h0F, 5'h1F, 5'h00, 5'h00, 5'h00};
    logic [13:0] rates [0:3] = '{14'h02ED, 14'h02EE, 14'h3200, 14'h3201};
    int num_errors = 0;
    int n_checks = 0;
    logic [15:0] ofsTab [0:23] = '{16'h0000, 16'h0002, 16'h0003, 16'h0004, 16'h0005, 16'h0006,
        16'h000C, 16'h000D, 16'h0080, 16'h0090, 16'h0091, 16'h0092, 16'h00A0, 16'h00A1, 16'h0100,
        16'h0101, 16'h0102, 16'h0103, 16'h0104, 16'h0105, 16'h0106, 16'h0107, 16'h0108, 16'h0109};
    logic [7:0] rstTab [0:23] = '{8'h30, 8'h00, 8'hA5, 8'h3C, 8'h5A, 8'h1E, 8'hD2, 8'hC3, 8'h40,
        8'h3C, 8'hA5, 8'h96, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h00, 8'h1F, 8'h00, 8'h00,
        8'h30, 8'h14};
    // read-only slots of the table above
    logic [23:0] roMask = 24'h000EFC;

    dsb_config_bank i_dsb_config_bank (.core_clk(core_clk), .rst(rst), .spiSclk(spiSclk),
        .spiCsN(spiCsN), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoEn(spiMisoEn),
        .sysrefPosition(sysrefPosition), .laneCountReq(laneCountReq),
        .testPatternSel(testPatternSel), .laneRateMbps(laneRateMbps),
        .datapathEnable(datapathEnable), .interpFactor(interpFactor), .linkI(linkI),
        .linkQ(linkQ), .constI(constI), .constQ(constQ), .linkEnable_q(linkEnable_q),
        .linkModeSelect_q(linkModeSelect_q), .linkStreamCount_q(linkStreamCount_q),
        .linkControl_q(linkControl_q), .resetBusy_q(resetBusy_q),
        .laneCount_q(laneCount_q), .laneCountOk_q(laneCountOk_q),
        .prbsOrder_q(prbsOrder_q), .laneRateOk_q(laneRateOk_q),
        .upConverterBypass_q(upConverterBypass_q), .complexSamples_q(complexSamples_q),
        .oscillatorOnlyMode_q(oscillatorOnlyMode_q), .mixI_q(mixI_q), .mixQ_q(mixQ_q),
        .mixSat_q(mixSat_q), .dacSample_q(dacSample_q));
    dsb_spi_host i_dsb_spi_host (.core_clk(core_clk), .spiSclk(spiSclk), .spiCsN(spiCsN),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoEn(spiMisoEn));

    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : chk
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        i_dsb_spi_host.xfer(1'b0, a[14:0], d, rdv);
    endtask : wr
    task automatic rdChk(input logic [15:0] a, input logic [7:0] exp);
        i_dsb_spi_host.xfer(1'b1, a[14:0], 8'h00, rdv);
        chk($sformatf("reg %h", a), {8'h00, exp}, {8'h00, rdv});
    endtask : rdChk
    task automatic settle;
        repeat (2) @(negedge core_clk);
    endtask : settle
    task automatic close_out;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        close_out();
    end

    initial begin
        logic [7:0] d;
        rst = 1'b1;
        repeat (2) @(negedge core_clk);
        rst = 1'b0;
        for (int i = 0; i < 24; i++) rdChk(ofsTab[i], rstTab[i]);
        $display("test reset values done");
        // link enable precedes the other link registers in table order and gets bit 0 clear, so it is off before link settings change
        for (int i = 0; i < 24; i++) begin
            d = rstTab[i] ^ 8'h5A;
            wr(ofsTab[i], d);
            if (roMask[i]) rdChk(ofsTab[i], rstTab[i]);
            else rdChk(ofsTab[i], (ofsTab[i] == 16'h0100) ? {7'h0, d[0]} : d);
        end
        rdChk(16'h0200, 8'h00);
        $display("test access kinds done");
        i_dsb_spi_host.halfCyc = 7;
        wr(16'h0100, 8'h00);
        wr(16'h0101, 8'h03);
        wr(16'h0100, 8'h01);
        i_dsb_spi_host.halfCyc = 4;
        settle();
        chk("link on", 16'h0001, {15'h0, linkEnable_q});
        chk("bypass", 16'h0000, {15'h0, upConverterBypass_q});
        chk("complex", 16'h0001, {15'h0, complexSamples_q});
        chk("mode", 16'h0003, {8'h0, linkModeSelect_q});
        chk("streams", 16'h005B, {8'h0, linkStreamCount_q});
        $display("test link mode done");
        wr(16'h0000, 8'h80);
        chk("busy", 16'h0001, {15'h0, resetBusy_q});
        repeat (16) @(negedge core_clk);
        chk("idle", 16'h0000, {15'h0, resetBusy_q});
        for (int i = 0; i < 24; i++) rdChk(ofsTab[i], rstTab[i]);
        settle();
        chk("bypass", 16'h0001, {15'h0, upConverterBypass_q});
        chk("real out", linkI, dacSample_q);
        chk("ctrl", 16'h0003, {8'h0, linkControl_q});
        $display("test soft reset done");
        for (int n = 0; n < 18; n++) begin
            laneCountReq = n[4:0];
            settle();
            chk("lanes ok", {15'h0, n inside {1, 2, 3, 4, 6, 8, 12, 16}},
                {15'h0, laneCountOk_q});
        end
        chk("lanes", 16'h0010, {11'h0, laneCount_q});
        for (int s = 0; s < 8; s++) begin
            testPatternSel = s[2:0];
            settle();
            chk("prbs", {11'h0, prbsExp[s]}, {11'h0, prbsOrder_q});
        end
        for (int r = 0; r < 4; r++) begin
            laneRateMbps = rates[r];
            settle();
            chk("rate ok", {15'h0, r inside {1, 2}}, {15'h0, laneRateOk_q});
        end
        $display("test link limits done");
        datapathEnable = 1'b1;
        for (int f = 1; f < 3; f++) begin
            interpFactor = f[8:0];
            constI = 16'sd16384;
            constQ = 16'sd0;
            settle();
            chk("osc only", {15'h0, f == 2}, {15'h0, oscillatorOnlyMode_q});
        end
        chk("mix i", 16'sd16384, mixI_q);
        chk("no sat", 16'h0000, {15'h0, mixSat_q});
        constI = 16'sd32767;
        constQ = 16'sd1;
        settle();
        chk("sat", 16'h0001, {15'h0, mixSat_q});
        chk("mix q", 16'h0001, mixQ_q);
        wr(16'h0100, 8'h01);
        settle();
        chk("osc off", 16'h0000, {15'h0, oscillatorOnlyMode_q});
        chk("mix link", linkI, mixI_q);
        $display("test oscillator done");
        close_out();
    end
endmodule : dsb_config_bank_tb
`default_nettype wire
